//--- core/plt_line_timing.sv
// Line timing, heartbeat, link pulse bursts and management registers of a 10/100 PHY
`timescale 1ns/1ps

// Function
// - Cut off long 10M transmit, then unjab later
// - Heartbeat on col about 1 us after 10M transmit
// - Heartbeat pulse lasts about 1 us
// - Burst clock pulses 125 us apart, 100 ns
// - Data one pulse 62.5 us after clock
// - Bursts repeat every 12 ms, 2 ms long
// - Each burst has 17 clock, 16 data slots
// - Leave internal reset within 300 us powerup
// - Management ready within 200 us after reset
// - Registers are 16 bits, numbered by frame
// - Numbers 0 to 8 are base registers
// - Vendor registers at 16-20, 26 and 30
module plt_line_timing
  import plt_pkg::*;
#(
  parameter logic [27:0] JABBER_CYCLES = 28'(JAB_CYC),
  parameter logic [27:0] UNJAB_CYCLES = 28'(UNJAB_CYC),
  parameter logic [21:0] BURST_REPEAT_CYCLES = 22'(FLP_REP_CYC),
  parameter logic [13:0] PULSE_HALF_CYCLES = 14'(FLP_HALF_CYC),
  parameter logic [15:0] RECOVERY_CYCLES = 16'(RECOV_CYC),
  parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary value
  parameter logic [15:0] ID_LOW = 16'h5678 // Arbitrary value
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  input wire logic tx_en,
  input wire logic link_up,
  input wire logic an_complete,
  input wire logic [15:0] partner_ability,
  input wire logic [15:0] an_expansion,
  input wire logic [15:0] np_incoming,
  output logic tx_gate,
  output logic col,
  output logic flp_out,
  output logic jabber,
  output logic mgmt_ready
);

  // Pin synchronisers
  logic [1:0] mdc_sync_ff, mdio_sync_ff, tx_sync_ff;
  logic [4:0] addr_meta_ff, addr_sync_ff;
  logic mdc_prev_ff, tx_prev_ff;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mdc_sync_ff <= 2'h0;
      mdio_sync_ff <= 2'h3;
      tx_sync_ff <= 2'h0;
      addr_meta_ff <= 5'h00;
      addr_sync_ff <= 5'h00;
      mdc_prev_ff <= 1'b0;
      tx_prev_ff <= 1'b0;
    end else begin
      mdc_sync_ff <= {mdc_sync_ff[0], mdc};
      mdio_sync_ff <= {mdio_sync_ff[0], mdio_in};
      tx_sync_ff <= {tx_sync_ff[0], tx_en};
      addr_meta_ff <= phy_addr;
      addr_sync_ff <= addr_meta_ff;
      mdc_prev_ff <= mdc_sync_ff[1];
      tx_prev_ff <= tx_sync_ff[1];
    end
  end
  logic mdc_rise, mdio_bit, tx_s;
  assign mdc_rise = mdc_sync_ff[1] & ~mdc_prev_ff;
  assign mdio_bit = mdio_sync_ff[1];
  assign tx_s = tx_sync_ff[1];

  // Reset recovery window
  logic [15:0] rec_cnt_ff, nxt_rec_cnt;
  logic ready_ff, nxt_ready;
  always_comb begin
    nxt_rec_cnt = rec_cnt_ff;
    nxt_ready = ready_ff;
    if (!ready_ff) begin
      if (rec_cnt_ff == RECOVERY_CYCLES - 16'h1) begin
        nxt_ready = 1'b1;
      end else begin
        nxt_rec_cnt = rec_cnt_ff + 16'h1;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rec_cnt_ff <= 16'h0;
      ready_ff <= 1'b0;
    end else begin
      rec_cnt_ff <= nxt_rec_cnt;
      ready_ff <= nxt_ready;
    end
  end

  // Register file
  logic [15:0] ctrl_ff, ability_ff, np_out_ff, port_ff, mask_ff, ind_ff, dig_ff, txt_ff;
  logic [15:0] nxt_ctrl, nxt_ability, nxt_np_out, nxt_port, nxt_mask, nxt_ind, nxt_dig, nxt_txt;
  logic wr_stb;
  logic [4:0] wr_reg;
  logic [15:0] wr_data, rd_word;
  logic [4:0] rd_reg;
  logic jabbed_ff, col_ff, flp_active_ff, tx_gate_ff;

  always_comb begin
    rd_word = 16'h0000;
    if (rd_reg == REG_BASIC_CONTROL) begin
      rd_word = ctrl_ff;
    end else if (rd_reg == REG_BASIC_STATUS) begin
      rd_word = STATUS_CAPS;
      rd_word[STAT_AN_DONE] = an_complete;
      rd_word[STAT_LINK] = link_up;
      rd_word[STAT_JABBER] = jabbed_ff;
    end else if (rd_reg == REG_IDENTIFIER_HIGH) begin
      rd_word = ID_HIGH;
    end else if (rd_reg == REG_IDENTIFIER_LOW) begin
      rd_word = ID_LOW;
    end else if (rd_reg == REG_AUTONEG_LOCAL_ABILITY) begin
      rd_word = ability_ff;
    end else if (rd_reg == REG_AUTONEG_PARTNER_ABILITY) begin
      rd_word = partner_ability;
    end else if (rd_reg == REG_AUTONEG_EXPANSION) begin
      rd_word = an_expansion;
    end else if (rd_reg == REG_NEXT_PAGE_OUTGOING) begin
      rd_word = np_out_ff;
    end else if (rd_reg == REG_NEXT_PAGE_INCOMING) begin
      rd_word = np_incoming;
    end else if (rd_reg == REG_PORT_SETUP) begin
      rd_word = port_ff;
    end else if (rd_reg == REG_SECONDARY_STATUS) begin
      rd_word = {12'h000, flp_active_ff, col_ff, jabbed_ff, tx_gate_ff};
    end else if (rd_reg == REG_IRQ_MASK) begin
      rd_word = mask_ff;
    end else if (rd_reg == REG_IRQ_FLAGS) begin
      rd_word = 16'h0000;
    end else if (rd_reg == REG_INDICATOR_SETUP) begin
      rd_word = ind_ff;
    end else if (rd_reg == REG_DIGITAL_SETUP) begin
      rd_word = dig_ff;
    end else if (rd_reg == REG_TX_TUNING) begin
      rd_word = txt_ff;
    end
  end

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ability = ability_ff;
    nxt_np_out = np_out_ff;
    nxt_port = port_ff;
    nxt_mask = mask_ff;
    nxt_ind = ind_ff;
    nxt_dig = dig_ff;
    nxt_txt = txt_ff;
    if (wr_stb) begin
      if (wr_reg == REG_BASIC_CONTROL) begin
        nxt_ctrl = wr_data;
        nxt_ctrl[CTRL_SW_RESET] = 1'b0;
        if (wr_data[CTRL_SW_RESET]) begin
          nxt_ctrl = CTRL_RESET_VAL;
          nxt_ability = ABILITY_RESET_VAL;
          nxt_np_out = ZERO_RESET_VAL;
        end
      end else if (wr_reg == REG_AUTONEG_LOCAL_ABILITY) begin
        nxt_ability = wr_data;
      end else if (wr_reg == REG_NEXT_PAGE_OUTGOING) begin
        nxt_np_out = wr_data;
      end else if (wr_reg == REG_PORT_SETUP) begin
        nxt_port = wr_data;
      end else if (wr_reg == REG_IRQ_MASK) begin
        nxt_mask = wr_data;
      end else if (wr_reg == REG_INDICATOR_SETUP) begin
        nxt_ind = wr_data;
      end else if (wr_reg == REG_DIGITAL_SETUP) begin
        nxt_dig = wr_data;
      end else if (wr_reg == REG_TX_TUNING) begin
        nxt_txt = wr_data;
      end
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= CTRL_RESET_VAL;
      ability_ff <= ABILITY_RESET_VAL;
      np_out_ff <= ZERO_RESET_VAL;
      port_ff <= ZERO_RESET_VAL;
      mask_ff <= ZERO_RESET_VAL;
      ind_ff <= ZERO_RESET_VAL;
      dig_ff <= ZERO_RESET_VAL;
      txt_ff <= ZERO_RESET_VAL;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ability_ff <= nxt_ability;
      np_out_ff <= nxt_np_out;
      port_ff <= nxt_port;
      mask_ff <= nxt_mask;
      ind_ff <= nxt_ind;
      dig_ff <= nxt_dig;
      txt_ff <= nxt_txt;
    end
  end

  // Management frame engine, sampling and driving on mdc rising edges
  plt_md_e md_st_ff, nxt_md_st;
  logic [5:0] pre_cnt_ff, nxt_pre_cnt;
  logic [4:0] bit_cnt_ff, nxt_bit_cnt;
  logic [12:0] head_ff, nxt_head;
  logic [15:0] sh_ff, nxt_sh;
  logic is_rd_ff, nxt_is_rd, md_out_ff, nxt_md_out, md_oe_ff, nxt_md_oe;
  logic [12:0] head_full;
  assign head_full = {head_ff[11:0], mdio_bit};
  assign rd_reg = head_full[4:0];
  assign wr_reg = head_ff[4:0];
  assign wr_data = nxt_sh;

  always_comb begin
    nxt_md_st = md_st_ff;
    nxt_pre_cnt = pre_cnt_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_head = head_ff;
    nxt_sh = sh_ff;
    nxt_is_rd = is_rd_ff;
    nxt_md_out = md_out_ff;
    nxt_md_oe = md_oe_ff;
    wr_stb = 1'b0;
    if (mdc_rise) begin
      case (md_st_ff)
        MD_IDLE: begin
          if (mdio_bit) begin
            nxt_pre_cnt = (pre_cnt_ff == MD_PRE_ONES) ? pre_cnt_ff : pre_cnt_ff + 6'h1;
          end else begin
            nxt_pre_cnt = 6'h00;
            if (pre_cnt_ff == MD_PRE_ONES) begin
              nxt_md_st = MD_HEAD;
              nxt_bit_cnt = 5'h00;
            end
          end
        end
        MD_HEAD: begin
          nxt_head = head_full;
          nxt_bit_cnt = bit_cnt_ff + 5'h1;
          if (bit_cnt_ff == MD_HEAD_BITS - 5'h1) begin
            nxt_bit_cnt = 5'h00;
            nxt_md_st = MD_IDLE;
            nxt_is_rd = (head_full[11:10] == MD_OP_RD);
            nxt_sh = rd_word;
            if (head_full[12] && head_full[9:5] == addr_sync_ff && ready_ff &&
                (head_full[11:10] == MD_OP_RD || head_full[11:10] == MD_OP_WR)) begin
              nxt_md_st = MD_TA;
            end
          end
        end
        MD_TA: begin
          nxt_bit_cnt = bit_cnt_ff + 5'h1;
          if (is_rd_ff) begin
            nxt_md_oe = 1'b1;
            nxt_md_out = 1'b0;
            nxt_bit_cnt = 5'h00;
            nxt_md_st = MD_DATA;
          end else if (bit_cnt_ff == 5'h1) begin
            nxt_bit_cnt = 5'h00;
            nxt_md_st = MD_DATA;
          end
        end
        MD_DATA: begin
          nxt_bit_cnt = bit_cnt_ff + 5'h1;
          if (is_rd_ff) begin
            nxt_md_out = sh_ff[15];
            nxt_sh = {sh_ff[14:0], 1'b0};
            if (bit_cnt_ff == MD_DATA_BITS) begin
              nxt_md_oe = 1'b0;
              nxt_md_out = 1'b0;
              nxt_md_st = MD_IDLE;
            end
          end else begin
            nxt_sh = {sh_ff[14:0], mdio_bit};
            if (bit_cnt_ff == MD_DATA_BITS - 5'h1) begin
              wr_stb = 1'b1;
              nxt_md_st = MD_IDLE;
            end
          end
        end
        default: nxt_md_st = MD_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      md_st_ff <= MD_IDLE;
      pre_cnt_ff <= 6'h00;
      bit_cnt_ff <= 5'h00;
      head_ff <= 13'h0000;
      sh_ff <= 16'h0000;
      is_rd_ff <= 1'b0;
      md_out_ff <= 1'b0;
      md_oe_ff <= 1'b0;
    end else begin
      md_st_ff <= nxt_md_st;
      pre_cnt_ff <= nxt_pre_cnt;
      bit_cnt_ff <= nxt_bit_cnt;
      head_ff <= nxt_head;
      sh_ff <= nxt_sh;
      is_rd_ff <= nxt_is_rd;
      md_out_ff <= nxt_md_out;
      md_oe_ff <= nxt_md_oe;
    end
  end

  // Jabber and heartbeat
  logic [27:0] jab_cnt_ff, nxt_jab_cnt;
  logic [9:0] sqe_cnt_ff, nxt_sqe_cnt;
  logic nxt_jabbed, nxt_col, nxt_tx_gate, ten_mode;
  assign ten_mode = ~ctrl_ff[CTRL_SPEED_LSB];
  always_comb begin
    nxt_jab_cnt = jab_cnt_ff + 28'h1;
    nxt_jabbed = jabbed_ff;
    if (!jabbed_ff) begin
      if (!(ten_mode && tx_s)) begin
        nxt_jab_cnt = 28'h0;
      end else if (jab_cnt_ff == JABBER_CYCLES - 28'h1) begin
        nxt_jabbed = 1'b1;
        nxt_jab_cnt = 28'h0;
      end
    end else if (jab_cnt_ff == UNJAB_CYCLES - 28'h1) begin
      nxt_jabbed = 1'b0;
      nxt_jab_cnt = 28'h0;
    end
    nxt_tx_gate = tx_s & ~nxt_jabbed;
    nxt_sqe_cnt = 10'h000;
    if (sqe_cnt_ff != 10'h000 && sqe_cnt_ff != 10'(SQE_DLY_CYC + SQE_WID_CYC)) begin
      nxt_sqe_cnt = sqe_cnt_ff + 10'h1;
    end else if (tx_prev_ff && !tx_s && ten_mode && !jabbed_ff) begin
      nxt_sqe_cnt = 10'h001;
    end
    nxt_col = (nxt_sqe_cnt > 10'(SQE_DLY_CYC));
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      jab_cnt_ff <= 28'h0;
      jabbed_ff <= 1'b0;
      tx_gate_ff <= 1'b0;
      sqe_cnt_ff <= 10'h000;
      col_ff <= 1'b0;
    end else begin
      jab_cnt_ff <= nxt_jab_cnt;
      jabbed_ff <= nxt_jabbed;
      tx_gate_ff <= nxt_tx_gate;
      sqe_cnt_ff <= nxt_sqe_cnt;
      col_ff <= nxt_col;
    end
  end

  // Fast link pulse bursts, one slot per half clock period
  logic [21:0] rep_cnt_ff, nxt_rep_cnt;
  logic [13:0] slot_tmr_ff, nxt_slot_tmr;
  logic [5:0] slot_ff, nxt_slot;
  logic [15:0] word_ff, nxt_word;
  logic nxt_flp_active, flp_ff, nxt_flp;
  always_comb begin
    nxt_rep_cnt = rep_cnt_ff + 22'h1;
    nxt_slot_tmr = slot_tmr_ff;
    nxt_slot = slot_ff;
    nxt_word = word_ff;
    nxt_flp_active = flp_active_ff;
    if (!ctrl_ff[CTRL_AN_ENABLE] || !ready_ff) begin
      nxt_rep_cnt = 22'h0;
      // Pulse in flight keeps its full width
      nxt_slot_tmr = slot_tmr_ff + 14'h1;
      nxt_flp_active = flp_ff;
    end else if (rep_cnt_ff == BURST_REPEAT_CYCLES - 22'h1) begin
      nxt_rep_cnt = 22'h0;
      nxt_flp_active = 1'b1;
      nxt_slot = 6'h00;
      nxt_slot_tmr = 14'h0;
      nxt_word = ability_ff;
    end else if (flp_active_ff) begin
      nxt_slot_tmr = slot_tmr_ff + 14'h1;
      if (slot_tmr_ff == PULSE_HALF_CYCLES - 14'h1) begin
        nxt_slot_tmr = 14'h0;
        nxt_slot = slot_ff + 6'h1;
        if (slot_ff == FLP_LAST_SLOT) begin
          nxt_flp_active = 1'b0;
        end
      end
    end
    nxt_flp = nxt_flp_active && (nxt_slot_tmr < 14'(FLP_PW_CYC)) &&
              (!nxt_slot[0] || nxt_word[nxt_slot[4:1]]);
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rep_cnt_ff <= 22'h0;
      slot_tmr_ff <= 14'h0;
      slot_ff <= 6'h00;
      word_ff <= 16'h0000;
      flp_active_ff <= 1'b0;
      flp_ff <= 1'b0;
    end else begin
      rep_cnt_ff <= nxt_rep_cnt;
      slot_tmr_ff <= nxt_slot_tmr;
      slot_ff <= nxt_slot;
      word_ff <= nxt_word;
      flp_active_ff <= nxt_flp_active;
      flp_ff <= nxt_flp;
    end
  end

  assign mdio_out = md_out_ff;
  assign mdio_oe = md_oe_ff;
  assign tx_gate = tx_gate_ff;
  assign col = col_ff;
  assign flp_out = flp_ff;
  assign jabber = jabbed_ff;
  assign mgmt_ready = ready_ff;

endmodule // plt_line_timing

//--- core/plt_pkg.sv
// Constants for the line timing and management register block
package plt_pkg;

  localparam int CLK_NS = 4;

  // Jabber cutoff and unjab timers
  localparam int JAB_MS = 100;
  localparam int UNJAB_MS = 500;
  localparam int JAB_CYC = JAB_MS * 1000000 / CLK_NS;
  localparam int UNJAB_CYC = UNJAB_MS * 1000000 / CLK_NS;

  // Heartbeat delay and width, least times rounded up
  localparam int SQE_DLY_NS = 1000;
  localparam int SQE_WID_NS = 1000;
  localparam int SQE_DLY_CYC = (SQE_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SQE_WID_CYC = (SQE_WID_NS + CLK_NS - 1) / CLK_NS;

  // Fast link pulse timing
  localparam int FLP_PW_NS = 100;
  localparam int FLP_HALF_NS = 62500;
  localparam int FLP_REP_US = 12000;
  localparam int FLP_PW_CYC = FLP_PW_NS / CLK_NS;
  localparam int FLP_HALF_CYC = FLP_HALF_NS / CLK_NS;
  localparam int FLP_REP_CYC = FLP_REP_US * 1000 / CLK_NS;
  localparam logic [5:0] FLP_LAST_SLOT = 6'h20;

  // Reset recovery before management access, longest time rounded down
  localparam int RECOV_US = 200;
  localparam int RECOV_CYC = RECOV_US * 1000 / CLK_NS;

  // Management frame
  localparam logic [5:0] MD_PRE_ONES = 6'h20;
  localparam logic [4:0] MD_HEAD_BITS = 5'h0d;
  localparam logic [4:0] MD_DATA_BITS = 5'h10;
  localparam logic [1:0] MD_OP_WR = 2'h1;
  localparam logic [1:0] MD_OP_RD = 2'h2;

  // Register numbers
  localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_IDENTIFIER_HIGH = 5'h02;
  localparam logic [4:0] REG_IDENTIFIER_LOW = 5'h03;
  localparam logic [4:0] REG_AUTONEG_LOCAL_ABILITY = 5'h04;
  localparam logic [4:0] REG_AUTONEG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] REG_AUTONEG_EXPANSION = 5'h06;
  localparam logic [4:0] REG_NEXT_PAGE_OUTGOING = 5'h07;
  localparam logic [4:0] REG_NEXT_PAGE_INCOMING = 5'h08;
  localparam logic [4:0] REG_PORT_SETUP = 5'h10;
  localparam logic [4:0] REG_SECONDARY_STATUS = 5'h11;
  localparam logic [4:0] REG_IRQ_MASK = 5'h12;
  localparam logic [4:0] REG_IRQ_FLAGS = 5'h13;
  localparam logic [4:0] REG_INDICATOR_SETUP = 5'h14;
  localparam logic [4:0] REG_DIGITAL_SETUP = 5'h1a;
  localparam logic [4:0] REG_TX_TUNING = 5'h1e;

  // Field positions and reset values
  localparam int CTRL_SW_RESET = 15;
  localparam int CTRL_SPEED_LSB = 13;
  localparam int CTRL_AN_ENABLE = 12;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h3100;
  localparam logic [15:0] ABILITY_RESET_VAL = 16'h01e1;
  localparam logic [15:0] ZERO_RESET_VAL = 16'h0000;
  localparam logic [15:0] STATUS_CAPS = 16'h7809;
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_LINK = 2;
  localparam int STAT_JABBER = 1;

  typedef enum logic [1:0] {
    MD_IDLE = 2'b00,
    MD_HEAD = 2'b01,
    MD_TA = 2'b10,
    MD_DATA = 2'b11
  } plt_md_e;

endpackage

//--- test/plt_properties.sv
// Port-level timing checks for the line timing block
`timescale 1ns/1ps
module plt_properties
  import plt_pkg::*;
#(
  parameter logic [27:0] JABBER_CYCLES = 28'h00000c8,
  parameter logic [27:0] UNJAB_CYCLES = 28'h0000190,
  parameter logic [15:0] RECOVERY_CYCLES = 16'h0014
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tx_en,
  input wire logic mdio_oe,
  input wire logic tx_gate,
  input wire logic col,
  input wire logic flp_out,
  input wire logic jabber,
  input wire logic mgmt_ready
);
  logic [15:0] col_ff, idle_ff, txon_ff, jab_ff, flp_ff, rdy_ff;
  logic [15:0] nxt_col, nxt_idle, nxt_txon, nxt_jab, nxt_flp, nxt_rdy;

  // Saturating run length of a level
  function automatic logic [15:0] run(input logic on, input logic [15:0] c);
    return on ? c + {15'h0000, c != 16'hffff} : 16'h0000;
  endfunction

  always_comb begin
    nxt_col = run(col, col_ff);
    nxt_idle = run(!tx_en, idle_ff);
    nxt_txon = run(tx_en, txon_ff);
    nxt_jab = run(jabber, jab_ff);
    nxt_flp = run(flp_out, flp_ff);
    nxt_rdy = run(1'b1, rdy_ff);
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      {col_ff, idle_ff, txon_ff, jab_ff, flp_ff, rdy_ff} <= '0;
    end else begin
      {col_ff, idle_ff, txon_ff, jab_ff, flp_ff, rdy_ff} <= {nxt_col, nxt_idle, nxt_txon, nxt_jab, nxt_flp, nxt_rdy};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_tx_quiet;
    !tx_en [*5];
  endsequence
  sequence s_col_end;
    $fell(col);
  endsequence

  a_sqe_delay: assert property ($rose(col) |-> idle_ff >= 16'd163 && idle_ff <= 16'd400)
    else $error("heartbeat start out of window");
  a_sqe_width: assert property (s_col_end |-> col_ff == 16'(SQE_WID_CYC))
    else $error("heartbeat width wrong");
  a_jab_gate: assert property (jabber |-> !tx_gate)
    else $error("transmit passed while jabbered");
  a_gate_idle: assert property (s_tx_quiet |-> !tx_gate)
    else $error("transmit gate without enable");
  a_jab_start: assert property ($rose(jabber) |-> txon_ff >= 16'(JABBER_CYCLES) && txon_ff <= 16'(JABBER_CYCLES) + 16'd8)
    else $error("jabber cutoff time wrong");
  a_unjab_time: assert property ($fell(jabber) |-> jab_ff >= 16'(UNJAB_CYCLES) - 16'd2 && jab_ff <= 16'(UNJAB_CYCLES) + 16'd2)
    else $error("unjab time wrong");
  a_flp_width: assert property ($fell(flp_out) |-> flp_ff == 16'(FLP_PW_CYC))
    else $error("link pulse width wrong");
  a_ready_time: assert property ($rose(mgmt_ready) |-> rdy_ff >= RECOVERY_CYCLES - 16'd2 && rdy_ff <= RECOVERY_CYCLES + 16'd2)
    else $error("recovery time wrong");
  a_ready_holds: assert property (mgmt_ready |=> mgmt_ready)
    else $error("ready dropped outside reset");
  a_oe_ready: assert property (mdio_oe |-> mgmt_ready)
    else $error("data driven before recovery");
endmodule // plt_properties

bind plt_line_timing plt_properties #(
  .JABBER_CYCLES(JABBER_CYCLES), .UNJAB_CYCLES(UNJAB_CYCLES), .RECOVERY_CYCLES(RECOVERY_CYCLES)
) i_props (
  .sys_clk(sys_clk), .reset(reset), .tx_en(tx_en), .mdio_oe(mdio_oe), .tx_gate(tx_gate), .col(col),
  .flp_out(flp_out), .jabber(jabber), .mgmt_ready(mgmt_ready)
);

//--- test/plt_sta_model.sv
// Management station model: clock and data of the management port
`timescale 1ns/1ps
module plt_sta_model
  import plt_pkg::*;
(
  output logic mdc,
  output logic sta_oe,
  output logic sta_val,
  input wire logic mdio
);
  initial begin
    mdc = 1'b0;
    sta_oe = 1'b0;
    sta_val = 1'b1;
  end

  task automatic put_bit(input logic b);
    sta_oe = 1'b1;
    sta_val = b;
    #24 mdc = 1'b1;
    #24 mdc = 1'b0;
  endtask

  // One whole frame; clock stands low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regn,
                       input logic [15:0] wd, output logic [15:0] rd, output logic ta_ok);
    logic [45:0] head;
    logic [17:0] w;
    head = {32'hffffffff, 2'b01, op, phy, regn};
    w = {2'b10, wd};
    rd = 16'h0000;
    ta_ok = 1'b1;
    for (int i = 45; i >= 0; i--) put_bit(head[i]);
    if (op == MD_OP_WR) begin
      for (int i = 17; i >= 0; i--) put_bit(w[i]);
    end else begin
      sta_oe = 1'b0;
      for (int k = 1; k <= 18; k++) begin
        #24 mdc = 1'b1;
        #24 mdc = 1'b0;
        if (k == 1) ta_ok = (mdio === 1'b0);
        else if (k <= 17) rd[17 - k] = mdio;
      end
    end
    sta_oe = 1'b0;
  endtask
endmodule // plt_sta_model

//--- test/tb.sv
// Self-checking bench for the line timing and management block
`timescale 1ns/1ps
module tb
  import plt_pkg::*;
;
  localparam logic [27:0] JAB = 28'h00000c8;
  localparam logic [27:0] UNJAB = 28'h0000190;
  localparam logic [21:0] REP = 22'h000bb8;
  localparam logic [13:0] HALF = 14'h0028;
  localparam logic [15:0] RECOV = 16'h0014;
  localparam logic [15:0] PA = 16'hc5e1;
  localparam logic [15:0] AE = 16'h0003;
  localparam logic [15:0] NP = 16'h2a55;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic tx_en = 1'b0;
  logic link_up = 1'b0;
  logic mdc, mdio_out, mdio_oe, sta_oe, sta_val, tx_gate, col, flp_out, jabber, mgmt_ready;
  wire logic mdio_line;
  int bad_count = 0;
  int checked = 0;

  // Line has a pull-up when nobody drives it
  assign mdio_line = mdio_oe ? mdio_out : (sta_oe ? sta_val : 1'b1);
  always #2 sys_clk = ~sys_clk;

  plt_line_timing #(
    .JABBER_CYCLES(JAB), .UNJAB_CYCLES(UNJAB), .BURST_REPEAT_CYCLES(REP), .PULSE_HALF_CYCLES(HALF),
    .RECOVERY_CYCLES(RECOV), .ID_HIGH(16'h1234), .ID_LOW(16'h5678) // Arbitrary identifiers
  ) i_dut (
    .sys_clk(sys_clk), .reset(reset), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .phy_addr(5'h05), .tx_en(tx_en), .link_up(link_up), .an_complete(1'b1), .partner_ability(PA),
    .an_expansion(AE), .np_incoming(NP), .tx_gate(tx_gate), .col(col), .flp_out(flp_out), .jabber(jabber),
    .mgmt_ready(mgmt_ready)
  );
  plt_sta_model i_sta (.mdc(mdc), .sta_oe(sta_oe), .sta_val(sta_val), .mdio(mdio_line));

  task automatic stop_test();
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return mgmt_ready;
      1: return col;
      2: return jabber;
      default: return flp_out;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task automatic wait_for(input int s, input logic lvl, input int lim, output int n);
    n = 0;
    while (pick(s) !== lvl) begin
      if (n >= lim) begin
        check(n, 0);
        stop_test();
      end
      tick();
      n++;
    end
  endtask
  task automatic wr(input logic [4:0] r, input logic [15:0] v);
    logic [15:0] d;
    logic ta;
    i_sta.frame(MD_OP_WR, 5'h05, r, v, d, ta);
  endtask
  task automatic rd_chk(input logic [4:0] r, input logic [15:0] e);
    logic [15:0] d;
    logic ta;
    i_sta.frame(MD_OP_RD, 5'h05, r, 16'h0000, d, ta);
    check(ta, 1'b1);
    check(d, e);
  endtask

  task automatic t_ready();
    int n;
    reset = 1'b1;
    repeat (4) tick();
    reset = 1'b0;
    wait_for(0, 1'b1, 100, n);
    check(n <= int'(RECOV) + 2, 1'b1);
    repeat (RECOV) tick();
  endtask

  task automatic t_flp();
    logic [32:0] got, exp;
    logic prev, off;
    int n;
    for (int s = 0; s < 33; s++) exp[s] = s[0] ? ABILITY_RESET_VAL[s / 2] : 1'b1;
    got = 33'h000000001;
    prev = 1'b1;
    off = 1'b0;
    wait_for(3, 1'b1, 4000, n);
    for (int c = 1; c < 1500; c++) begin
      tick();
      if (flp_out === 1'b1 && prev !== 1'b1) begin
        if (c % int'(HALF) == 0 && c / int'(HALF) < 33) got[c / int'(HALF)] = 1'b1;
        else off = 1'b1;
      end
      prev = flp_out;
    end
    check(got, exp);
    check(off, 1'b0);
    wait_for(3, 1'b1, 4000, n);
    check(1499 + n, int'(REP));
  endtask

  task automatic t_regs();
    logic [4:0] rn [21] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
                           5'h0f, 5'h10, 5'h12, 5'h13, 5'h14, 5'h15, 5'h1a, 5'h1b, 5'h1e, 5'h1f};
    logic [15:0] ev [21] = '{CTRL_RESET_VAL, STATUS_CAPS | 16'h0024, 16'h1234, 16'h5678, ABILITY_RESET_VAL,
                             PA, AE, 16'h0000, NP, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                             16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    link_up = 1'b1;
    for (int i = 0; i < 21; i++) rd_chk(rn[i], ev[i]);
  endtask

  task automatic t_write();
    logic [4:0] rw [7] = '{5'h04, 5'h07, 5'h10, 5'h12, 5'h14, 5'h1a, 5'h1e};
    logic [4:0] ro [6] = '{5'h02, 5'h05, 5'h09, 5'h0f, 5'h15, 5'h1f};
    logic [15:0] re [6] = '{16'h1234, PA, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      wr(rw[i], 16'h5a3c);
      rd_chk(rw[i], 16'h5a3c);
    end
    for (int i = 0; i < 6; i++) begin
      wr(ro[i], 16'h5a3c);
      rd_chk(ro[i], re[i]);
    end
    wr(REG_BASIC_CONTROL, 16'h8000);
    rd_chk(REG_BASIC_CONTROL, CTRL_RESET_VAL);
    rd_chk(REG_AUTONEG_LOCAL_ABILITY, ABILITY_RESET_VAL);
    rd_chk(REG_NEXT_PAGE_OUTGOING, 16'h0000);
  endtask

  // Frames with a foreign address or a bad opcode are ignored
  task automatic t_refuse();
    logic [15:0] d;
    logic ta;
    i_sta.frame(MD_OP_WR, 5'h06, REG_IRQ_MASK, 16'h0000, d, ta);
    i_sta.frame(MD_OP_RD, 5'h06, REG_IRQ_MASK, 16'h0000, d, ta);
    check({ta, d}, 17'h0ffff);
    i_sta.frame(2'h3, 5'h05, REG_IRQ_MASK, 16'h0000, d, ta);
    check({ta, d}, 17'h0ffff);
    rd_chk(REG_IRQ_MASK, 16'h5a3c);
  endtask

  task automatic t_jab();
    int n;
    wr(REG_BASIC_CONTROL, 16'h0000);
    tx_en = 1'b1;
    wait_for(2, 1'b1, 1000, n);
    check(n >= int'(JAB) && n <= int'(JAB) + 8, 1'b1);
    tick();
    check(tx_gate, 1'b0);
    wait_for(2, 1'b0, 1000, n);
    check(n >= int'(UNJAB) - 3 && n <= int'(UNJAB) + 3, 1'b1);
    repeat (2) tick();
    check(tx_gate, 1'b1);
    tx_en = 1'b0;
    repeat (700) tick();
  endtask

  task automatic t_hb();
    int n, w;
    tx_en = 1'b1;
    repeat (50) tick();
    tx_en = 1'b0;
    wait_for(1, 1'b1, 600, n);
    check(n >= 163 && n <= 400, 1'b1);
    wait_for(1, 1'b0, 600, w);
    check(w >= 125 && w <= 375, 1'b1);
    wr(REG_BASIC_CONTROL, 16'h2000);
    tx_en = 1'b1;
    repeat (50) tick();
    tx_en = 1'b0;
    n = 0;
    repeat (600) begin
      tick();
      n += (col !== 1'b0);
    end
    check(n, 0);
    rd_chk(REG_SECONDARY_STATUS, 16'h0000);
  endtask

  initial begin
    t_ready();
    t_flp();
    t_regs();
    t_write();
    t_refuse();
    t_jab();
    t_hb();
    t_ready();
    rd_chk(REG_BASIC_CONTROL, CTRL_RESET_VAL);
    stop_test();
  end
endmodule // tb
